// >>> hw/mgpt_consts.vh
// Constants for the motion GPIO, PWM and trigger bus block
// How it works
// RL1 - Thirty-two GPIO lines form four byte ports, written and read per byte; the code always writes and reads all four bytes together as one word.
// RL2 - Each GPIO line has its own software direction and polarity.
// RL3 - Two PWM generators, each with its own period and duty.
// RL4 - PWM high time is proportional to the programmed duty value.
// RL5 - Software picks internal clock or external clock pin as PWM time base.
// RL6 - PWM runs only from software settings, no servo loop coupling.
// RL7 - Trigger bus lines can feed trigger inputs or carry breakpoints and encoder signals.
// RL8 - Trigger bus lines can serve as generic digital I/O.
// RL9 - Breakpoint on trigger bus is an output-only active-high pulse of 90 to 120 ns.
// RL10 - Encoder and index on trigger bus are output-only, taken after the input filter.
// RL11 - Trigger inputs and generic I/O pass through unaltered.
// RL12 - Trigger input polarity and edge are programmable before capture.
// RL13 - After reset GPIO lines are non-inverted inputs and PWM outputs idle low.
`ifndef MGPT_CONSTS_VH
`define MGPT_CONSTS_VH
// Register byte addresses
`define MGPT_ADDR_PORT_OUT   12'h000
`define MGPT_ADDR_PORT_DIR   12'h004
`define MGPT_ADDR_PORT_POL   12'h008
`define MGPT_ADDR_PORT_IN    12'h00c
`define MGPT_ADDR_PWM_CTRL   12'h010
`define MGPT_ADDR_PWM1_PER   12'h014
`define MGPT_ADDR_PWM1_DUTY  12'h018
`define MGPT_ADDR_PWM2_PER   12'h01c
`define MGPT_ADDR_PWM2_DUTY  12'h020
`define MGPT_ADDR_TRIG_SEL   12'h024
`define MGPT_ADDR_TRIG_OUT   12'h028
`define MGPT_ADDR_TRIG_IN    12'h02c
`define MGPT_ADDR_TRIG_CFG   12'h030
`define MGPT_ADDR_STRAP      12'h034
// Route codes per trigger bus line, 3 bits each
`define MGPT_ROUTE_GPIO_IN   3'h0
`define MGPT_ROUTE_GPIO_OUT  3'h1
`define MGPT_ROUTE_BKPT1     3'h2
`define MGPT_ROUTE_BKPT2     3'h3
`define MGPT_ROUTE_ENC1      3'h4
`define MGPT_ROUTE_ENC2      3'h5
// Encoder sub-signal fixed by line number, no select bits within trig select field (bits 25:24 not stored)
// Breakpoint pulse: 90 to 120 ns window, at 100 ns clock
`define MGPT_CLK_NS          100
`define MGPT_BKPT_MIN_NS     90
`define MGPT_BKPT_CYC        ((`MGPT_BKPT_MIN_NS + `MGPT_CLK_NS - 1) / `MGPT_CLK_NS)
// Reset values
`define MGPT_RST_DIR         32'h0000_0000
`define MGPT_RST_POL         32'h0000_0000
`define MGPT_RST_PWM_CTRL    4'h0
`define MGPT_RST_PERIOD      16'hffff
`define MGPT_RST_DUTY        16'h0000
`define MGPT_RST_TRIG_SEL    32'h0000_0000
// PWM control fields
`define MGPT_PWM_EN1_BIT     0
`define MGPT_PWM_EN2_BIT     1
`define MGPT_PWM_EXT1_BIT    2
`define MGPT_PWM_EXT2_BIT    3
`endif

// >>> hw/mgpt_top.v
// Motion GPIO ports, PWM generators and trigger bus router with APB slave
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mgpt_consts.vh"
module mgpt_top #(
   parameter NUM_TRIG = 8,
   parameter PWM_W    = 16
) (
   input  wire                  clk_in,
   input  wire                  rst_n_in,
   // APB slave
   input  wire                  psel_in,
   input  wire                  penable_in,
   input  wire                  pwrite_in,
   input  wire [11:0]           paddr_in,
   input  wire [31:0]           pwdata_in,
   output reg  [31:0]           prdata_out,
   output wire                  pready_out,
   output wire                  pslverr_out,
   // General-purpose port pins
   input  wire [31:0]           gpio_in,
   output reg  [31:0]           gpio_out,
   output reg  [31:0]           gpio_oe_n_out,
   // PWM and external clock
   input  wire                  pwm_ext_clk_in,
   output reg  [1:0]            pwm_out,
   // Power-up pull strap
   input  wire                  powerup_pull_select_in,
   // Trigger bus pins
   input  wire [NUM_TRIG-1:0]   inter_board_trigger_bus_in,
   output reg  [NUM_TRIG-1:0]   inter_board_trigger_bus_out,
   output reg  [NUM_TRIG-1:0]   inter_board_trigger_bus_oe_n_out,
   // Encoder side, same clock domain
   input  wire [1:0]            bkpt_event_in,
   input  wire [2:0]            enc1_filt_in,
   input  wire [2:0]            enc2_filt_in,
   output reg  [1:0]            trig_capture_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   reg        rst_s1;
   reg        rst_s2;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   wire rst_n = rst_s2;

   reg [31:0]         gpio_s1;
   reg [31:0]         gpio_s2;
   reg [NUM_TRIG-1:0] trig_s1;
   reg [NUM_TRIG-1:0] trig_s2;
   reg [1:0]          pclk_s;
   reg                pclk_d;
   reg                strap_s1;
   reg                strap_s2;
   // Only the second stage is read by logic, plus the delayed copy pclk_d of the external clock for edge detection
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gpio_s1  <= 32'h0000_0000;
         gpio_s2  <= 32'h0000_0000;
         trig_s1  <= {NUM_TRIG{1'b0}};
         trig_s2  <= {NUM_TRIG{1'b0}};
         pclk_s   <= 2'h0;
         pclk_d   <= 1'b0;
         strap_s1 <= 1'b1;
         strap_s2 <= 1'b1;
      end else begin
         gpio_s1  <= gpio_in;
         gpio_s2  <= gpio_s1;
         trig_s1  <= inter_board_trigger_bus_in;
         trig_s2  <= trig_s1;
         pclk_s   <= {pclk_s[0], pwm_ext_clk_in};
         pclk_d   <= pclk_s[1];
         strap_s1 <= powerup_pull_select_in;
         strap_s2 <= strap_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg [31:0]          port_out;
   reg [31:0]          port_dir;     // 1 = output
   reg [31:0]          port_pol;     // 1 = inverted
   reg [3:0]           pwm_ctrl;
   reg [PWM_W-1:0]     pwm_per  [0:1];
   reg [PWM_W-1:0]     pwm_duty [0:1];
   reg [3*NUM_TRIG-1:0] trig_sel;
   reg [NUM_TRIG-1:0]  trig_gpo;
   reg [7:0]           trig_cfg;     // Per input: src[2:0], pol_inv
   reg                 strap_latched;

   wire wr_en = psel_in & penable_in & pwrite_in;

   // Byte lane write helper for the bytewise GPIO ports
   function [31:0] mgpt_byte_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  lanes;
      integer      i;
      begin
         mgpt_byte_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               mgpt_byte_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // A word write updates all four byte ports together through the lane mask
   wire [3:0] lanes = 4'hf;

   // Software writes; registers only change at access phase of a write
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         port_out    <= 32'h0000_0000;
         port_dir    <= `MGPT_RST_DIR;               // see RL13
         port_pol    <= `MGPT_RST_POL;               // see RL13
         pwm_ctrl    <= `MGPT_RST_PWM_CTRL;          // see RL13
         pwm_per[0]  <= `MGPT_RST_PERIOD;
         pwm_per[1]  <= `MGPT_RST_PERIOD;
         pwm_duty[0] <= `MGPT_RST_DUTY;
         pwm_duty[1] <= `MGPT_RST_DUTY;
         trig_sel    <= {3*NUM_TRIG{1'b0}};
         trig_gpo    <= {NUM_TRIG{1'b0}};
         trig_cfg    <= 8'h00;
      end else if (wr_en) begin
         case (paddr_in)
            `MGPT_ADDR_PORT_OUT:  port_out <= mgpt_byte_merge(port_out, pwdata_in, lanes); // see RL1
            `MGPT_ADDR_PORT_DIR:  port_dir <= pwdata_in;                                   // see RL2
            `MGPT_ADDR_PORT_POL:  port_pol <= pwdata_in;                                   // see RL2
            `MGPT_ADDR_PWM_CTRL:  pwm_ctrl <= pwdata_in[3:0];                              // see RL5
            `MGPT_ADDR_PWM1_PER:  pwm_per[0]  <= pwdata_in[PWM_W-1:0];                     // see RL3
            `MGPT_ADDR_PWM1_DUTY: pwm_duty[0] <= pwdata_in[PWM_W-1:0];
            `MGPT_ADDR_PWM2_PER:  pwm_per[1]  <= pwdata_in[PWM_W-1:0];
            `MGPT_ADDR_PWM2_DUTY: pwm_duty[1] <= pwdata_in[PWM_W-1:0];
            `MGPT_ADDR_TRIG_SEL:  trig_sel <= pwdata_in[3*NUM_TRIG-1:0];                   // see RL7
            `MGPT_ADDR_TRIG_OUT:  trig_gpo <= pwdata_in[NUM_TRIG-1:0];                     // see RL8
            `MGPT_ADDR_TRIG_CFG:  trig_cfg <= pwdata_in[7:0];                              // see RL12
            default: ;
         endcase
      end
   end

   // Strap caught once the synchroniser holds the pin, not its own reset value
   reg [1:0] strap_wait;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         strap_wait    <= 2'h0;
         strap_latched <= 1'b1;
      end else if (strap_wait != 2'h3) begin
         strap_wait <= strap_wait + 2'h1;
         if (strap_wait == 2'h2) begin
            strap_latched <= strap_s2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // GPIO pins, polarity applied on both directions
   wire [31:0] port_in_val = gpio_s2 ^ port_pol;   // see RL2
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gpio_out      <= 32'h0000_0000;
         gpio_oe_n_out <= 32'hffff_ffff;           // see RL13
      end else begin
         gpio_out      <= port_out ^ port_pol;     // see RL2
         gpio_oe_n_out <= ~port_dir;               // see RL2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM generators; software-only settings, no servo loop inputs
   reg  [PWM_W-1:0] pwm_cnt [0:1];
   wire             pclk_rise = pclk_s[1] & ~pclk_d;
   integer          g;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pwm_cnt[0] <= {PWM_W{1'b0}};
         pwm_cnt[1] <= {PWM_W{1'b0}};
         pwm_out    <= 2'b00;                                   // see RL13
      end else begin
         for (g = 0; g < 2; g = g + 1) begin
            if (!pwm_ctrl[`MGPT_PWM_EN1_BIT + g]) begin        // see RL6
               pwm_cnt[g] <= {PWM_W{1'b0}};
               pwm_out[g] <= 1'b0;
            end else if (!pwm_ctrl[`MGPT_PWM_EXT1_BIT + g] || pclk_rise) begin // see RL5
               pwm_cnt[g] <= (pwm_cnt[g] >= pwm_per[g]) ? {PWM_W{1'b0}} : pwm_cnt[g] + 1'b1; // see RL3
               pwm_out[g] <= (pwm_cnt[g] < pwm_duty[g]);       // see RL4
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Breakpoint pulse stretchers, one clock at 10 MHz gives 100 ns
   localparam integer BKPT_CYC_I = `MGPT_BKPT_CYC;
   localparam [3:0]   BKPT_CYC   = BKPT_CYC_I[3:0];
   reg [3:0] bkpt_cnt [0:1];
   reg [1:0] bkpt_pulse;
   integer   b;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         bkpt_cnt[0] <= 4'h0;
         bkpt_cnt[1] <= 4'h0;
         bkpt_pulse  <= 2'b00;
      end else begin
         for (b = 0; b < 2; b = b + 1) begin
            if (bkpt_event_in[b] && bkpt_cnt[b] == 4'h0) begin
               bkpt_cnt[b]   <= BKPT_CYC;          // see RL9
               bkpt_pulse[b] <= 1'b1;
            end else if (bkpt_cnt[b] > 4'h1) begin
               bkpt_cnt[b] <= bkpt_cnt[b] - 4'h1;
            end else begin
               bkpt_cnt[b]   <= 4'h0;
               bkpt_pulse[b] <= 1'b0;              // see RL9
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger bus routing; encoder signals taken already filtered
   // Line k carries phase (k mod 3) of the chosen encoder
   integer k;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         inter_board_trigger_bus_out      <= {NUM_TRIG{1'b0}};
         inter_board_trigger_bus_oe_n_out <= {NUM_TRIG{1'b1}};
      end else begin
         for (k = 0; k < NUM_TRIG; k = k + 1) begin
            inter_board_trigger_bus_oe_n_out[k] <= (trig_sel[3*k +: 3] == `MGPT_ROUTE_GPIO_IN);
            case (trig_sel[3*k +: 3])
               `MGPT_ROUTE_GPIO_OUT: inter_board_trigger_bus_out[k] <= trig_gpo[k];     // see RL11
               `MGPT_ROUTE_BKPT1:    inter_board_trigger_bus_out[k] <= bkpt_pulse[0];   // see RL9
               `MGPT_ROUTE_BKPT2:    inter_board_trigger_bus_out[k] <= bkpt_pulse[1];   // see RL9
               `MGPT_ROUTE_ENC1:     inter_board_trigger_bus_out[k] <= enc1_filt_in[k % 3]; // see RL10
               `MGPT_ROUTE_ENC2:     inter_board_trigger_bus_out[k] <= enc2_filt_in[k % 3]; // see RL10
               default:              inter_board_trigger_bus_out[k] <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger inputs from bus: raw line selected, then polarity and edge
   wire [2:0] src1 = trig_cfg[2:0];
   wire [2:0] src2 = trig_cfg[6:4];
   wire [1:0] trig_lvl;
   reg  [1:0] trig_lvl_d;
   assign trig_lvl[0] = trig_s2[src1 % NUM_TRIG] ^ trig_cfg[3];  // see RL12
   assign trig_lvl[1] = trig_s2[src2 % NUM_TRIG] ^ trig_cfg[7];  // see RL12
   // Active edge after polarity: rising of the corrected level
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         trig_lvl_d       <= 2'b00;
         trig_capture_out <= 2'b00;
      end else begin
         trig_lvl_d       <= trig_lvl;
         trig_capture_out <= trig_lvl & ~trig_lvl_d;  // see RL12
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read mux; zero wait states, unmapped reads zero with error
   reg addr_hit;
   always @* begin
      addr_hit = 1'b1;
      case (paddr_in)
         `MGPT_ADDR_PORT_OUT:  prdata_out = port_out;
         `MGPT_ADDR_PORT_DIR:  prdata_out = port_dir;
         `MGPT_ADDR_PORT_POL:  prdata_out = port_pol;
         `MGPT_ADDR_PORT_IN:   prdata_out = port_in_val;                 // see RL1
         `MGPT_ADDR_PWM_CTRL:  prdata_out = {28'h0000000, pwm_ctrl};
         `MGPT_ADDR_PWM1_PER:  prdata_out = {{(32-PWM_W){1'b0}}, pwm_per[0]};
         `MGPT_ADDR_PWM1_DUTY: prdata_out = {{(32-PWM_W){1'b0}}, pwm_duty[0]};
         `MGPT_ADDR_PWM2_PER:  prdata_out = {{(32-PWM_W){1'b0}}, pwm_per[1]};
         `MGPT_ADDR_PWM2_DUTY: prdata_out = {{(32-PWM_W){1'b0}}, pwm_duty[1]};
         `MGPT_ADDR_TRIG_SEL:  prdata_out = {{(32-3*NUM_TRIG){1'b0}}, trig_sel};
         `MGPT_ADDR_TRIG_OUT:  prdata_out = {{(32-NUM_TRIG){1'b0}}, trig_gpo};
         `MGPT_ADDR_TRIG_IN:   prdata_out = {{(32-NUM_TRIG){1'b0}}, trig_s2}; // see RL8
         `MGPT_ADDR_TRIG_CFG:  prdata_out = {24'h000000, trig_cfg};
         `MGPT_ADDR_STRAP:     prdata_out = {31'h00000000, strap_latched};
         default: begin
            prdata_out = 32'h0000_0000;
            addr_hit   = 1'b0;
         end
      endcase
   end

   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~addr_hit;

endmodule
`default_nettype wire

// >>> test/mgpt_monitor.sv
// Port checker for the motion GPIO, PWM and trigger bus block
`timescale 1ns/1ns
`default_nettype none
`include "mgpt_consts.vh"
module mgpt_monitor #(
   parameter NUM_TRIG = 8
) (
   input wire logic                clk_in,
   input wire logic                rst_n_in,
   input wire logic                psel_in,
   input wire logic                penable_in,
   input wire logic                pwrite_in,
   input wire logic [11:0]         paddr_in,
   input wire logic [31:0]         pwdata_in,
   input wire logic [31:0]         prdata_out,
   input wire logic                pready_out,
   input wire logic                pslverr_out,
   input wire logic [31:0]         gpio_out,
   input wire logic [31:0]         gpio_oe_n_out,
   input wire logic [1:0]          pwm_out,
   input wire logic [NUM_TRIG-1:0] inter_board_trigger_bus_out,
   input wire logic [NUM_TRIG-1:0] inter_board_trigger_bus_oe_n_out,
   input wire logic [1:0]          bkpt_event_in,
   input wire logic [1:0]          trig_capture_out
);
   logic        wr;
   logic [31:0] dir, pol, pout, ctrl, sel, tout;
   ////////////////////////////////////////////////////////////
   // Shadow of the steering registers; only exact hits count, refused writes do not
   assign wr = psel_in && penable_in && pwrite_in && pready_out;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dir <= 32'h0;
         pol <= 32'h0;
         pout <= 32'h0;
         ctrl <= 32'h0;
         sel <= 32'h0;
         tout <= 32'h0;
      end else if (wr) begin
         if (paddr_in == `MGPT_ADDR_PORT_DIR) dir <= pwdata_in;
         if (paddr_in == `MGPT_ADDR_PORT_POL) pol <= pwdata_in;
         if (paddr_in == `MGPT_ADDR_PORT_OUT) pout <= pwdata_in;
         if (paddr_in == `MGPT_ADDR_PWM_CTRL) ctrl <= pwdata_in;
         if (paddr_in == `MGPT_ADDR_TRIG_SEL) sel <= pwdata_in;
         if (paddr_in == `MGPT_ADDR_TRIG_OUT) tout <= pwdata_in;
      end
   end
   ////////////////////////////////////////////////////////////
   // One edge of pin latency, so compare only once the shadow has settled
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_gpio_drive:
   assert property ($stable(dir) |-> gpio_oe_n_out == ~dir) else $error("direction not on enables");
   a_gpio_level:
   assert property ($stable(pout ^ pol) |-> gpio_out == (pout ^ pol)) else $error("pin level wrong");
   a_pwm_idle:
   assert property ($stable(ctrl[1:0]) |-> (pwm_out & ~ctrl[1:0]) == 2'b00) else $error("disabled pwm active");
   a_line_route:
   assert property ($stable(sel[2:0]) |-> inter_board_trigger_bus_oe_n_out[0] == (sel[2:0] == 3'h0))
      else $error("trigger line direction wrong");
   a_line_pass:
   assert property ($stable(sel[5:3]) && $stable(tout[1]) && sel[5:3] == `MGPT_ROUTE_GPIO_OUT
      |-> inter_board_trigger_bus_out[1] == tout[1]) else $error("generic line altered");
   a_bkpt_start:
   assert property (sel[2:0] == `MGPT_ROUTE_BKPT1 && $stable(sel[2:0]) && bkpt_event_in[0]
      && !$past(bkpt_event_in[0]) && !inter_board_trigger_bus_out[0] |-> ##2 inter_board_trigger_bus_out[0])
      else $error("breakpoint pulse missing");
   a_bkpt_width:
   assert property ($rose(inter_board_trigger_bus_out[0]) && sel[2:0] == `MGPT_ROUTE_BKPT1
      |=> !inter_board_trigger_bus_out[0]) else $error("breakpoint pulse too long");
   a_capture_once:
   assert property (|trig_capture_out |=> trig_capture_out == 2'b00) else $error("capture pulse too long");
   a_unmapped_err:
   assert property (psel_in && penable_in && paddr_in > `MGPT_ADDR_STRAP |-> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire

// >>> test/mgpt_partner.sv
// Model of the equipment wired to the general-purpose port
`timescale 1ns/1ns
`default_nettype none
module mgpt_partner (
   input  wire logic [31:0] dev_level_in,
   input  wire logic [31:0] dev_oe_n_in,
   input  wire logic        pull_up_in,
   input  wire logic [31:0] drv_in,
   input  wire logic [31:0] drv_en_in,
   output wire logic [31:0] wire_out
);
   ////////////////////////////////////////////////////////////
   // Device wins where it drives, then our driver, else the strap pull; never a stale value
   assign wire_out = (dev_level_in & ~dev_oe_n_in) | (drv_in & drv_en_in & dev_oe_n_in)
                   | ({32{pull_up_in}} & ~drv_en_in & dev_oe_n_in);
endmodule
`default_nettype wire

// >>> test/motion_gpio_pwm_trigger_bus_tb_top.sv
// Self-checking testbench for the motion GPIO, PWM and trigger bus block
`timescale 1ns/1ns
`default_nettype none
`include "mgpt_consts.vh"
module motion_gpio_pwm_trigger_bus_tb_top;
   logic        clk_in = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_clk = 1'b0;
   logic        pull = 1'b0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, drv = 32'h0, drv_en = 32'h0, prdata, gpio_in, gpio_out, gpio_oe_n, rd, k;
   logic [1:0]  pwm, cap, bkpt = 2'b00;
   logic [2:0]  enc1 = 3'b000, enc2 = 3'b010;
   logic [7:0]  tb_in = 8'h00, trig_in, trig_out, trig_oe_n;
   logic [4:0]  watch;
   int          miscompares = 0, n_checks = 0;
   ////////////////////////////////////////////////////////////
   // Clock, trigger wire resolution and the watched pulse lines
   always #50 clk_in = ~clk_in;
   assign trig_in = (trig_out & ~trig_oe_n) | (tb_in & trig_oe_n);
   assign watch = {cap, trig_out[0], pwm};
   mgpt_top #(.NUM_TRIG(8), .PWM_W(16)) i_dut (
      .clk_in(clk_in), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n), .pwm_ext_clk_in(ext_clk),
      .pwm_out(pwm), .powerup_pull_select_in(pull), .inter_board_trigger_bus_in(trig_in),
      .inter_board_trigger_bus_out(trig_out), .inter_board_trigger_bus_oe_n_out(trig_oe_n),
      .bkpt_event_in(bkpt), .enc1_filt_in(enc1), .enc2_filt_in(enc2), .trig_capture_out(cap));
   mgpt_partner i_far (.dev_level_in(gpio_out), .dev_oe_n_in(gpio_oe_n), .pull_up_in(pull),
      .drv_in(drv), .drv_en_in(drv_en), .wire_out(gpio_in));
   ////////////////////////////////////////////////////////////
   // Bus cycle; the idle edge at the end keeps strobes from toggling twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) begin
         @(posedge clk_in);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Count high cycles of one watched line
   task automatic hi(input int i, input int n);
      k = 32'h0;
      repeat (n) begin
         @(posedge clk_in);
         k = k + watch[i];
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk(gpio_oe_n, 32'hffff_ffff);
      chk({30'h0, pwm}, 32'h0);
      apb(1'b0, `MGPT_ADDR_PORT_POL, 32'h0);
      chk(rd, `MGPT_RST_POL);
      apb(1'b0, `MGPT_ADDR_STRAP, 32'h0);
      chk(rd, {31'h0, pull});
      apb(1'b0, 12'h040, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
   endtask
   task automatic t_gpio;
      drv <= 32'h0012_3400;
      drv_en <= 32'h00ff_ff00;
      apb(1'b1, `MGPT_ADDR_PORT_DIR, 32'h0000_00ff);
      apb(1'b1, `MGPT_ADDR_PORT_POL, 32'h0000_0f0f);
      apb(1'b1, `MGPT_ADDR_PORT_OUT, 32'h0000_00a5);
      repeat (4) @(posedge clk_in);
      chk(gpio_oe_n, 32'hffff_ff00);
      chk(gpio_out, 32'h0000_0faa);
      apb(1'b0, `MGPT_ADDR_PORT_IN, 32'h0);
      chk(rd, 32'h0012_3ba5);
   endtask
   // Period of five ticks; high time must follow the duty value
   task automatic t_pwm;
      apb(1'b1, `MGPT_ADDR_PWM1_PER, 32'h4);
      apb(1'b1, `MGPT_ADDR_PWM_CTRL, 32'h1);
      for (int d = 2; d <= 4; d += 2) begin
         apb(1'b1, `MGPT_ADDR_PWM1_DUTY, d);
         hi(0, 20);
         chk(k, 4 * d);
      end
      apb(1'b1, `MGPT_ADDR_PWM2_PER, 32'h1);
      apb(1'b1, `MGPT_ADDR_PWM2_DUTY, 32'h1);
      apb(1'b1, `MGPT_ADDR_PWM_CTRL, 32'hb);
      hi(1, 8);
      chk(k, 32'h0);
      ext_clk <= 1'b1;
      hi(1, 4);
      chk(k, 32'h1);
      ext_clk <= 1'b0;
      hi(1, 8);
      chk(k, 32'h8);
      apb(1'b1, `MGPT_ADDR_PWM_CTRL, 32'h0);
      hi(0, 8);
      chk(k, 32'h0);
   endtask
   // Line 0 breakpoint, line 1 generic out, line 2 encoder index, line 3 trigger source
   task automatic t_trig;
      apb(1'b1, `MGPT_ADDR_TRIG_SEL, 32'h0001_d10a);
      apb(1'b1, `MGPT_ADDR_TRIG_OUT, 32'h2);
      enc1 <= 3'b100;
      repeat (4) @(posedge clk_in);
      chk({24'h0, trig_oe_n}, 32'hc8);
      chk({24'h0, trig_out}, 32'h16);
      enc1 <= 3'b011;
      bkpt <= 2'b01;
      @(posedge clk_in);
      bkpt <= 2'b00;
      hi(2, 6);
      chk(k, 32'h1);
      chk({24'h0, trig_out}, 32'h12);
      apb(1'b1, `MGPT_ADDR_TRIG_CFG, 32'h3);
      tb_in <= 8'h08;
      hi(3, 8);
      chk(k, 32'h1);
      apb(1'b0, `MGPT_ADDR_TRIG_IN, 32'h0);
      chk(rd, 32'h0000_001a);
      apb(1'b1, `MGPT_ADDR_TRIG_CFG, 32'hbb);
      tb_in <= 8'h00;
      hi(3, 8);
      chk(k, 32'h1);
      tb_in <= 8'h08;
      hi(4, 8);
      chk(k, 32'h0);
      tb_in <= 8'h00;
      hi(4, 8);
      chk(k, 32'h1);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_in);
      t_reset;
      t_gpio;
      t_pwm;
      t_trig;
      tally_and_finish;
   end
   // Watchdog, far beyond the fewer than two hundred cycles the scenarios need
   initial begin
      #2_000_000;
      miscompares++;
      tally_and_finish;
   end
endmodule
bind mgpt_top mgpt_monitor #(.NUM_TRIG(NUM_TRIG)) i_mon (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n_out), .pwm_out(pwm_out),
   .inter_board_trigger_bus_out(inter_board_trigger_bus_out),
   .inter_board_trigger_bus_oe_n_out(inter_board_trigger_bus_oe_n_out),
   .bkpt_event_in(bkpt_event_in), .trig_capture_out(trig_capture_out));
`default_nettype wire
